// ### design/afm_regs.vh
// Register offsets, field positions, reset values and sizes for the result and bus-master block
`ifndef AFM_REGS_VH
`define AFM_REGS_VH
`define AFM_OFF_SINGLE_FILL      12'h084
`define AFM_OFF_SCAN_FILL        12'h088
`define AFM_OFF_SINGLE_FLUSH     12'h08c
`define AFM_OFF_SCAN_FLUSH       12'h090
`define AFM_OFF_MASTER_DIS       12'h094
`define AFM_ADDR_W               12
`define AFM_CNT_W                3
`define AFM_FLUSH_BIT            0
`define AFM_MDIS_LSB             2
`define AFM_MDIS_MSB             9
`define AFM_NBUS                 8
`define AFM_MDIS_RESET           8'h00
`define AFM_FIFO_DEPTH           4
`define AFM_DATA_W               16
`endif

// ### design/afm_result_fifo.v
// Result FIFO with fill count and flush
`timescale 1ns/1ps
`include "afm_regs.vh"
module afm_result_fifo
(
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     flush,
    input  wire                     wr_valid,
    output wire                     wr_ready,
    input  wire [`AFM_DATA_W-1:0]   wr_data,
    input  wire                     rd_pop,
    output wire                     rd_valid,
    output reg  [`AFM_DATA_W-1:0]   rd_data,
    output wire [`AFM_CNT_W-1:0]    unread_count
);
    reg [`AFM_DATA_W-1:0] mem [0:`AFM_FIFO_DEPTH-1];
    reg [1:0]             wptr_reg;
    reg [1:0]             rptr_reg;
    reg [`AFM_CNT_W-1:0]  cnt_reg;
    wire                  do_wr;
    wire                  do_rd;
    assign wr_ready     = (cnt_reg != 3'h4) && !flush;
    assign rd_valid     = (cnt_reg != 3'h0);
    assign do_wr        = wr_valid && wr_ready;
    assign do_rd        = rd_pop && rd_valid && !flush;
    assign unread_count = cnt_reg;
    always @(posedge pclk)
    begin
        if (do_wr)
            mem[wptr_reg] <= wr_data;
    end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr_reg <= 2'h0;
            rptr_reg <= 2'h0;
            cnt_reg  <= 3'h0;
            rd_data  <= 16'h0000;
        end
        else if (flush)
        begin
            // Flush empties; a write in the same cycle is refused
            wptr_reg <= 2'h0;
            rptr_reg <= 2'h0;
            cnt_reg  <= 3'h0;
        end
        else
        begin
            if (do_wr)
                wptr_reg <= wptr_reg + 2'h1;
            if (do_rd)
            begin
                rptr_reg <= rptr_reg + 2'h1;
                rd_data  <= mem[rptr_reg];
            end
            if (do_wr && !do_rd)
                cnt_reg <= cnt_reg + 3'h1;
            else if (do_rd && !do_wr)
                cnt_reg <= cnt_reg - 3'h1;
        end
    end
endmodule // afm_result_fifo

// ### design/afm_bus_master.v
// Result fill levels, flush triggers and shared analog bus master control over APB
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "afm_regs.vh"
module afm_bus_master
(
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`AFM_ADDR_W-1:0]   paddr,
    input  wire [31:0]              pwdata,
    output wire                     pready,
    output reg  [31:0]              prdata,
    output wire                     pslverr,
    input  wire                     single_wr_valid,
    output wire                     single_wr_ready,
    input  wire [`AFM_DATA_W-1:0]   single_wr_data,
    input  wire                     single_rd_pop,
    output wire                     single_rd_valid,
    output wire [`AFM_DATA_W-1:0]   single_rd_data,
    input  wire                     scan_wr_valid,
    output wire                     scan_wr_ready,
    input  wire [`AFM_DATA_W-1:0]   scan_wr_data,
    input  wire                     scan_rd_pop,
    output wire                     scan_rd_valid,
    output wire [`AFM_DATA_W-1:0]   scan_rd_data,
    input  wire [`AFM_NBUS-1:0]     bus_selected,
    output reg  [`AFM_NBUS-1:0]     bus_request,
    output reg  [`AFM_NBUS-1:0]     bus_master,
    output reg  [`AFM_NBUS-1:0]     bus_monitor,
    output wire [`AFM_NBUS-1:0]     bus_master_off
);
    // ****************************************************
    // APB decode
    // ****************************************************
    reg  [`AFM_NBUS-1:0]  mdis_reg;
    reg  [31:0]           rdata_next;
    reg                   hit;
    wire                  wr_en;
    wire                  rd_en;
    wire                  single_flush;
    wire                  scan_flush;
    wire [`AFM_CNT_W-1:0] single_cnt;
    wire [`AFM_CNT_W-1:0] scan_cnt;
    wire [11:0]           word_addr;
    assign word_addr = {paddr[`AFM_ADDR_W-1:2], 2'b00};
    assign pready    = 1'b1;
    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && !penable && !pwrite;
    assign pslverr   = psel && penable && !hit;
    always @*
    begin
        hit = 1'b1;
        if (word_addr == `AFM_OFF_SINGLE_FILL)
            hit = 1'b1;
        else if (word_addr == `AFM_OFF_SCAN_FILL)
            hit = 1'b1;
        else if (word_addr == `AFM_OFF_SINGLE_FLUSH)
            hit = 1'b1;
        else if (word_addr == `AFM_OFF_SCAN_FLUSH)
            hit = 1'b1;
        else if (word_addr == `AFM_OFF_MASTER_DIS)
            hit = 1'b1;
        else
            hit = 1'b0;
    end
    // Flush triggers, writing zero does nothing
    assign single_flush = wr_en && (word_addr == `AFM_OFF_SINGLE_FLUSH)
                          && pwdata[`AFM_FLUSH_BIT];
    assign scan_flush   = wr_en && (word_addr == `AFM_OFF_SCAN_FLUSH)
                          && pwdata[`AFM_FLUSH_BIT];
    // ****************************************************
    // Read data
    // ****************************************************
    always @*
    begin
        rdata_next = 32'h0000_0000;
        if (word_addr == `AFM_OFF_SINGLE_FILL)
            rdata_next[`AFM_CNT_W-1:0] = single_cnt;
        else if (word_addr == `AFM_OFF_SCAN_FILL)
            rdata_next[`AFM_CNT_W-1:0] = scan_cnt;
        else if (word_addr == `AFM_OFF_MASTER_DIS)
            rdata_next[`AFM_MDIS_MSB:`AFM_MDIS_LSB] = mdis_reg;
        else
            rdata_next = 32'h0000_0000;
    end
    // Read data captured in setup, stable through access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= rdata_next;
    end
    // ****************************************************
    // Master-off register
    // ****************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mdis_reg <= `AFM_MDIS_RESET;
        else if (wr_en && (word_addr == `AFM_OFF_MASTER_DIS))
            mdis_reg <= pwdata[`AFM_MDIS_MSB:`AFM_MDIS_LSB];
    end
    assign bus_master_off = mdis_reg;
    // ****************************************************
    // Shared analog bus arbitration per bus
    // ****************************************************
    genvar i;
    generate
        for (i = 0; i < `AFM_NBUS; i = i + 1)
        begin : g_bus
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    bus_request[i] <= 1'b0;
                    bus_master[i]  <= 1'b0;
                    bus_monitor[i] <= 1'b0;
                end
                else
                begin
                    bus_request[i] <= bus_selected[i] && !mdis_reg[i];
                    bus_master[i]  <= bus_selected[i] && !mdis_reg[i];
                    bus_monitor[i] <= mdis_reg[i];
                end
            end
        end
    endgenerate
    // ****************************************************
    // Result FIFOs
    // ****************************************************
    afm_result_fifo u_single
    (
        .pclk         (pclk),
        .presetn      (presetn),
        .flush        (single_flush),
        .wr_valid     (single_wr_valid),
        .wr_ready     (single_wr_ready),
        .wr_data      (single_wr_data),
        .rd_pop       (single_rd_pop),
        .rd_valid     (single_rd_valid),
        .rd_data      (single_rd_data),
        .unread_count (single_cnt)
    );
    afm_result_fifo u_scan
    (
        .pclk         (pclk),
        .presetn      (presetn),
        .flush        (scan_flush),
        .wr_valid     (scan_wr_valid),
        .wr_ready     (scan_wr_ready),
        .wr_data      (scan_wr_data),
        .rd_pop       (scan_rd_pop),
        .rd_valid     (scan_rd_valid),
        .rd_data      (scan_rd_data),
        .unread_count (scan_cnt)
    );
endmodule // afm_bus_master

// ### sim/afm_chk.sv
// Assertions on the result and bus-master register block
`timescale 1ns/1ps
module afm_chk
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        single_rd_valid,
    input wire        scan_rd_valid,
    input wire [7:0]  bus_selected,
    input wire [7:0]  bus_request,
    input wire [7:0]  bus_master,
    input wire [7:0]  bus_monitor,
    input wire [7:0]  bus_master_off
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(a);
        psel && penable && pwrite && paddr[11:2] == a;
    endsequence
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr[11:2] == a;
    endsequence
    chk_req_sel: assert property ($past(presetn) |->
        bus_request == $past(bus_selected & ~bus_master_off)) else $error("request wrong");
    chk_master_req: assert property (bus_master == bus_request)
        else $error("master differs from request");
    chk_one_role: assert property ((bus_master & bus_monitor) == 8'h00)
        else $error("master and monitor together");
    chk_mon_off: assert property ($past(presetn) |->
        bus_monitor == $past(bus_master_off)) else $error("monitor wrong");
    chk_mdis_wr: assert property (s_wr(10'h025) |=>
        bus_master_off == $past(pwdata[9:2])) else $error("disable write lost");
    chk_single_flush: assert property (s_wr(10'h023) ##0 pwdata[0] |=>
        !single_rd_valid) else $error("single flush failed");
    chk_scan_flush: assert property (s_wr(10'h024) ##0 pwdata[0] |=>
        !scan_rd_valid) else $error("scan flush failed");
    chk_mdis_rd: assert property (s_rd(10'h025) |=>
        prdata == {22'h0, $past(bus_master_off), 2'b00}) else $error("disable read wrong");
    chk_cnt_rd: assert property (s_rd(10'h021) |=> prdata[31:3] == 0)
        else $error("count read wide");
    chk_scan_cnt_rd: assert property (s_rd(10'h022) |=> prdata[31:3] == 0)
        else $error("scan count read wide");
endmodule // afm_chk

// ### sim/afm_peer.sv
// Peer peripheral sharing the analog buses with the converter
`timescale 1ns/1ps
module afm_peer
(
    input  wire [7:0] bus_monitor,
    output wire [7:0] peer_master
);
    // Peer masters wherever the converter only watches
    assign peer_master = bus_monitor;
endmodule // afm_peer

// ### sim/tb_afm_bus_master.sv
// Self-checking bench for the result and bus-master register block
`timescale 1ns/1ps
module tb_afm_bus_master;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pe;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd, lf = 32'h2e42_4cc7;
    reg         swv = 0, srp = 0, cwv = 0, crp = 0;
    reg  [15:0] swd = 0, cwd = 0;
    reg  [7:0]  sel = 0, off;
    wire        pready, pslverr, swr, srv, cwr, crv;
    wire [31:0] prdata;
    wire [15:0] srd, crd;
    wire [7:0]  req, mst, mon, moff, peer;
    integer     err_total = 0, n_compared = 0, cyc = 0, i, j;
    int         cnt[2] = '{0, 0};
    int         sq[$];
    afm_bus_master u_afm_bus_master (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .single_wr_valid(swv), .single_wr_ready(swr),
        .single_wr_data(swd), .single_rd_pop(srp), .single_rd_valid(srv),
        .single_rd_data(srd), .scan_wr_valid(cwv), .scan_wr_ready(cwr), .scan_wr_data(cwd),
        .scan_rd_pop(crp), .scan_rd_valid(crv), .scan_rd_data(crd), .bus_selected(sel),
        .bus_request(req), .bus_master(mst), .bus_monitor(mon), .bus_master_off(moff));
    afm_peer u_afm_peer (.bus_monitor(mon), .peer_master(peer));
    initial forever #4 pclk = ~pclk;
    function [31:0] nx(input [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input [31:0] s, input [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        rd = prdata; pe = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task rchk(input [11:0] a, input [31:0] e);
        apb(0, a, 0); chk(rd, e);
        chk(pe, 0);
    endtask
    task push(input k, input integer n);
        for (j = 0; j < n; j++)
        begin
            lf = nx(lf);
            swd <= lf[15:0]; cwd <= lf[15:0]; swv <= !k; cwv <= k;
            @(posedge pclk);
            chk(k ? cwr : swr, cnt[k] < 4);
            if (cnt[k] < 4)
            begin
                cnt[k]++;
                if (!k) sq.push_back(lf[15:0]);
            end
        end
        swv <= 0; cwv <= 0;
        @(posedge pclk);
    endtask
    task pop(input k, input [15:0] e);
        chk(k ? crv : srv, 1);
        srp <= !k;
        crp <= k;
        @(posedge pclk);
        srp <= 0;
        crp <= 0;
        @(posedge pclk);
        chk(k ? crd : srd, e);
        cnt[k]--;
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            err_total++;
            complete_run;
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (i = 0; i < 5; i++) rchk(12'h084 + 4 * i, 0);
        $display("reset values done");
        push(0, 5); push(1, 3);
        pop(0, sq.pop_front());
        rchk(12'h084, cnt[0]);
        rchk(12'h088, cnt[1]);
        $display("fill levels done");
        for (i = 0; i < 2; i++)
        begin
            apb(1, 12'h08c + 4 * i, 32'h0000_0000);
            rchk(12'h084 + 4 * i, cnt[i]);
            apb(1, 12'h08c + 4 * i, 32'h0000_0001);
            cnt[i] = 0;
            if (i == 0) sq.delete();
            rchk(12'h084 + 4 * i, 0);
            chk(i ? crv : srv, 0);
            push(i, 1);
            rchk(12'h084 + 4 * i, 1);
            pop(i, lf[15:0]);
        end
        apb(0, 12'h0a0, 0);
        chk(pe, 1);
        chk(rd, 0);
        $display("flush done");
        for (i = 0; i < 8; i++)
        begin
            lf = nx(lf); off = lf[7:0]; sel <= lf[15:8];
            apb(1, 12'h094, {22'h0, off, 2'b00});
            rchk(12'h094, {22'h0, off, 2'b00});
            chk(req, sel & ~off); chk(mst, sel & ~off);
            chk(mon, off); chk(peer & mst, 0);
        end
        $display("bus master control done");
        push(0, 2);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        cnt[0] = 0;
        rchk(12'h084, 0);
        rchk(12'h094, 0);
        chk(mon, 0);
        chk(req, sel);
        $display("mid-run reset done");
        complete_run;
    end
endmodule // tb_afm_bus_master
bind afm_bus_master afm_chk u_afm_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .single_rd_valid(single_rd_valid), .scan_rd_valid(scan_rd_valid),
    .bus_selected(bus_selected), .bus_request(bus_request), .bus_master(bus_master),
    .bus_monitor(bus_monitor), .bus_master_off(bus_master_off));
